// [tpt_periodic_tick.sv]
// What this block does
// R1 - Divide oscillator clock, sized for 32.768 kHz.
// R2 - Disabled counter is held at zero.
// R3 - Enabled counter advances while enable stays set.
// R4 - Tap overflow sets read-only rollover flag.
// R5 - Flag with enable raises interrupt request.
// R6 - Writing one to acknowledge clears flag.
// R7 - Acknowledge bit always reads as zero.
// R8 - First flag at half period, then full.
// R9 - Codes 0-2 divide 32768, 8192, 2048.
// R10 - Codes 3-7 divide 128 down to 8.
// R11 - Software changes rate only while disabled.
// R12 - Keep counting in stop when oscillator kept.
// R13 - Otherwise inactive throughout stop mode.
// R14 - Keep counting and flagging in wait.
// R15 - Registers unreachable in wait or stop.
// R16 - Software disables block before low power.
// R17 - Reset clears run and interrupt enables.
// R18 - Fifteen-stage chain with eight selectable taps.
// R19 - Oscillator events synchronised before setting flag.
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ns
`include "tpt_regs.svh"

module tpt_periodic_tick (
  input  wire logic              ref_clk,           // Bus clock, 20 MHz.
  input  wire logic              reset_n,           // Async reset, low.
  input  wire logic              crystal_osc_clock, // Oscillator clock.
  input  wire logic              wait_mode,         // System in wait.
  input  wire logic              stop_mode,         // System in stop.
  input  wire logic              osc_run_in_stop,   // Oscillator kept in stop.
  input  wire tpt_pkg::tpt_addr_t addr,             // Register address.
  input  wire tpt_pkg::tpt_byte_t wr_data,          // Write data.
  input  wire logic              wr_en,             // Write strobe.
  input  wire logic              rd_en,             // Read strobe.
  output tpt_pkg::tpt_byte_t     rd_data,           // Read data, next cycle.
  output logic                   irq,               // Interrupt level.
  output logic                   wakeup             // Stop wakeup pulse.
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic                   counter_run_enable_r;
  logic                   counter_run_enable_nxt;
  logic                   rollover_irq_enable_r;
  logic                   rollover_irq_enable_nxt;
  logic                   rollover_flag_r;
  logic                   rollover_flag_nxt;
  tpt_pkg::tpt_rate_t     rate_select_r;
  tpt_pkg::tpt_rate_t     rate_select_nxt;
  tpt_pkg::tpt_byte_t     rd_data_r;
  tpt_pkg::tpt_byte_t     rd_data_nxt;
  logic                   irq_r;
  logic                   irq_nxt;
  logic                   wakeup_r;
  logic                   wakeup_nxt;
  logic                   osc_tick;
  logic                   tick_gated;
  logic                   rollover_p;
  logic                   bus_open;
  logic [`TPT_DIV_STAGES-1:0] chain;

  // Register view selected by an address, from the current state.
  function automatic tpt_pkg::tpt_byte_t read_view(
    input tpt_pkg::tpt_addr_t a,
    input logic               flag,
    input tpt_pkg::tpt_rate_t rate,
    input logic               ie,
    input logic               run
  );
    read_view = `TPT_RST_DATA;
    case (a)
      `TPT_OFS_CTRL: begin
        read_view[`TPT_BIT_FLAG]              = flag;
        read_view[`TPT_RATE_HI:`TPT_RATE_LO]  = rate;
        read_view[`TPT_BIT_IE]                = ie;
        read_view[`TPT_BIT_RUN]               = run;
      end
      `TPT_OFS_STATUS: read_view[`TPT_BIT_EVENT] = flag;
      `TPT_OFS_IRQ_EN: read_view[`TPT_BIT_EVENT] = ie;
      default:         read_view = `TPT_RST_DATA;
    endcase
  endfunction : read_view

  // ----------------------------------------------------------------------
  // Oscillator tick and divider chain
  // ----------------------------------------------------------------------
  // R19 synchronised oscillator edge
  tpt_osc_sync u_sync (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .crystal_osc_clock (crystal_osc_clock),
    .osc_tick          (osc_tick)
  );

  // Stop without a kept oscillator freezes the chain; wait does not.
  // R12 count on in stop
  // R13 inactive in stop
  // R14 count on in wait
  assign tick_gated = osc_tick & ~(stop_mode & ~osc_run_in_stop);

  // R1 oscillator divider chain
  // R18 fifteen stage chain
  tpt_divider #(
    .STAGES (`TPT_DIV_STAGES)
  ) u_div (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .osc_tick (tick_gated),
    .run      (counter_run_enable_r),
    .rate     (rate_select_r),
    .event_p  (rollover_p),
    .count    (chain)
  );

  // ----------------------------------------------------------------------
  // Register file and event logic
  // ----------------------------------------------------------------------
  // Software only reaches the registers while the system is awake.
  // R15 no access asleep
  assign bus_open = ~wait_mode & ~stop_mode;

  // Next state of the control bits, the flag and the outputs.  The rate
  // field is written whenever the control word is written; software must
  // disable the block first, as a live rate change can skip a period.
  always_comb begin
    counter_run_enable_nxt  = counter_run_enable_r;
    rollover_irq_enable_nxt = rollover_irq_enable_r;
    rate_select_nxt         = rate_select_r;
    rollover_flag_nxt       = rollover_flag_r;
    rd_data_nxt             = `TPT_RST_DATA;
    if (bus_open && wr_en) begin
      case (addr)
        `TPT_OFS_CTRL: begin
          counter_run_enable_nxt  = wr_data[`TPT_BIT_RUN];
          rollover_irq_enable_nxt = wr_data[`TPT_BIT_IE];
          rate_select_nxt         = wr_data[`TPT_RATE_HI:`TPT_RATE_LO];
          // R6 acknowledge clears flag
          if (wr_data[`TPT_BIT_ACK]) begin
            rollover_flag_nxt = 1'b0;
          end
        end
        `TPT_OFS_CLEAR: begin
          if (wr_data[`TPT_BIT_EVENT]) begin
            rollover_flag_nxt = 1'b0;
          end
        end
        `TPT_OFS_IRQ_EN: begin
          rollover_irq_enable_nxt = wr_data[`TPT_BIT_EVENT];
        end
        default: begin
          rollover_flag_nxt = rollover_flag_nxt;
        end
      endcase
    end
    // R4 rollover sets flag
    // A rollover in the same cycle as an acknowledge is kept.
    if (rollover_p) begin
      rollover_flag_nxt = 1'b1;
    end
    // R7 acknowledge reads zero
    if (bus_open && rd_en) begin
      rd_data_nxt = read_view(addr, rollover_flag_r, rate_select_r,
                              rollover_irq_enable_r, counter_run_enable_r);
    end
    // R5 interrupt request level
    irq_nxt    = rollover_flag_nxt & rollover_irq_enable_nxt;
    wakeup_nxt = rollover_p & stop_mode & rollover_irq_enable_r;
  end

  // Register stage.
  // R17 reset disables block
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_run_enable_r  <= 1'b0;
      rollover_irq_enable_r <= 1'b0;
      rollover_flag_r       <= 1'b0;
      rate_select_r         <= `TPT_RST_RATE;
      rd_data_r             <= `TPT_RST_DATA;
      irq_r                 <= 1'b0;
      wakeup_r              <= 1'b0;
    end else begin
      counter_run_enable_r  <= counter_run_enable_nxt;
      rollover_irq_enable_r <= rollover_irq_enable_nxt;
      rollover_flag_r       <= rollover_flag_nxt;
      rate_select_r         <= rate_select_nxt;
      rd_data_r             <= rd_data_nxt;
      irq_r                 <= irq_nxt;
      wakeup_r              <= wakeup_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign irq     = irq_r;
  assign wakeup  = wakeup_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // R2 held at zero
  hold_zero_a: assert property ( // R2
    !counter_run_enable_r |=> chain == '0)
    else $error("chain not held at zero while disabled");

  // R3 counter advances
  count_step_a: assert property ( // R3
    counter_run_enable_r && $past(counter_run_enable_r) && tick_gated
    |=> chain == $past(chain) + 15'h0001)
    else $error("chain did not advance on a tick");

  // R4 flag follows rollover
  flag_set_a: assert property ( // R4
    rollover_p |=> rollover_flag_r)
    else $error("rollover did not set the flag");

  // R5 interrupt level
  irq_level_a: assert property ( // R5
    rollover_flag_r && rollover_irq_enable_r |-> irq)
    else $error("enabled flag without interrupt");

  // R6 acknowledge clears
  ack_clear_a: assert property ( // R6
    bus_open && wr_en && addr == `TPT_OFS_CTRL
    && wr_data[`TPT_BIT_ACK] && !rollover_p |=> !rollover_flag_r)
    else $error("acknowledge did not clear the flag");

  // R6 zero write keeps flag
  ack_zero_a: assert property ( // R6
    rollover_flag_r && wr_en && !wr_data[`TPT_BIT_ACK]
    && !wr_data[`TPT_BIT_EVENT] |=> rollover_flag_r)
    else $error("flag lost without acknowledge");

  // R7 acknowledge reads zero
  ack_read_a: assert property ( // R7
    rd_en && addr == `TPT_OFS_CTRL |=> !rd_data[`TPT_BIT_ACK])
    else $error("acknowledge bit read as one");

  // R8 first rollover at half period for the fastest rate
  first_half_a: assert property ( // R8
    rollover_p && rate_select_r == 3'h7 && $stable(rate_select_r)
    |-> chain == 15'h0004 || chain[1:0] == 2'h0)
    else $error("rollover off the tap boundary");

  // R10 divide by eight tap
  tap_eight_a: assert property ( // R10
    rollover_p && rate_select_r == 3'h7 |-> chain[2:0] == 3'h4)
    else $error("divide by eight rollover misplaced");

  // R9 divide by 32768 tap
  tap_full_a: assert property ( // R9
    rollover_p && rate_select_r == 3'h0 |-> chain == 15'h4000)
    else $error("divide by 32768 rollover misplaced");

  // R13 stop freezes chain
  stop_freeze_a: assert property ( // R13
    stop_mode && !osc_run_in_stop && counter_run_enable_r
    |=> $stable(chain))
    else $error("chain moved in stop without oscillator");

  // R15 asleep writes ignored
  sleep_write_a: assert property ( // R15
    (wait_mode || stop_mode) && wr_en |=>
    $stable(counter_run_enable_r) && $stable(rate_select_r)
    && $stable(rollover_irq_enable_r))
    else $error("register written while asleep");

  // R15 asleep reads blank
  sleep_read_a: assert property ( // R15
    (wait_mode || stop_mode) && rd_en |=> rd_data == 8'h00)
    else $error("register read while asleep");

  // R19 event follows a tick
  sync_order_a: assert property ( // R19
    rollover_p |-> $past(tick_gated))
    else $error("rollover without a synchronised tick");

  // R9 divide by 2048 tap
  tap_2048_a: assert property ( // R9
    rollover_p && rate_select_r == 3'h2 && $stable(rate_select_r)
    |-> chain[10:0] == 11'h400)
    else $error("divide by 2048 rollover misplaced");

  // R10 divide by 128 tap
  tap_128_a: assert property ( // R10
    rollover_p && rate_select_r == 3'h3 && $stable(rate_select_r)
    |-> chain[6:0] == 7'h40)
    else $error("divide by 128 rollover misplaced");

  // R10 divide by 64 tap
  tap_64_a: assert property ( // R10
    rollover_p && rate_select_r == 3'h4 && $stable(rate_select_r)
    |-> chain[5:0] == 6'h20)
    else $error("divide by 64 rollover misplaced");

  // R10 divide by 32 tap
  tap_32_a: assert property ( // R10
    rollover_p && rate_select_r == 3'h5 && $stable(rate_select_r)
    |-> chain[4:0] == 5'h10)
    else $error("divide by 32 rollover misplaced");

  // R10 divide by 16 tap
  tap_16_a: assert property ( // R10
    rollover_p && rate_select_r == 3'h6 && $stable(rate_select_r)
    |-> chain[3:0] == 4'h8)
    else $error("divide by 16 rollover misplaced");

  // R14 counts in wait
  wait_count_a: assert property ( // R14
    wait_mode && !stop_mode && counter_run_enable_r && osc_tick
    |=> chain == $past(chain) + 15'h0001)
    else $error("chain stalled in wait mode");

  // R12 counts in stop
  stop_keep_a: assert property ( // R12
    stop_mode && osc_run_in_stop && counter_run_enable_r && osc_tick
    |=> chain == $past(chain) + 15'h0001)
    else $error("chain stalled in stop with oscillator kept");

  // R12 wakeup from stop
  wake_roll_a: assert property ( // R12
    rollover_p && stop_mode && rollover_irq_enable_r |=> wakeup)
    else $error("rollover in stop gave no wakeup");

  // R17 reset leaves block off
  reset_off_a: assert property ( // R17
    $rose(reset_n) |-> !counter_run_enable_r && !rollover_irq_enable_r
    && !irq)
    else $error("block not disabled after reset");

  // R5 masked flag quiet
  irq_mask_a: assert property ( // R5
    !rollover_irq_enable_r |-> !irq)
    else $error("interrupt raised while masked");

  // R7 clear register reads zero
  clear_read_a: assert property ( // R7
    rd_en && addr == `TPT_OFS_CLEAR |=> rd_data == 8'h00)
    else $error("write-only clear register read nonzero");

  // ----------------------------------------------------------------------
  // Cover properties
  // ----------------------------------------------------------------------
  // Main scenarios.
  first_roll_c: cover property (
    $rose(counter_run_enable_r) ##[1:300] rollover_p);
  roll_in_wait_c: cover property (
    wait_mode && rollover_p ##1 rollover_flag_r);
  wake_in_stop_c: cover property (
    stop_mode && osc_run_in_stop ##[1:1000] wakeup);
  ack_race_c: cover property (
    rollover_p && wr_en && wr_data[`TPT_BIT_ACK]);
  irq_raise_c: cover property (
    !irq ##1 irq);

endmodule : tpt_periodic_tick

// [tpt_regs.svh]
`ifndef TPT_REGS_SVH
`define TPT_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the 4-bit register port)
// ----------------------------------------------------------------------
`define TPT_OFS_CTRL      4'h0
`define TPT_OFS_STATUS    4'h4
`define TPT_OFS_CLEAR     4'h8
`define TPT_OFS_IRQ_EN    4'hC

// ----------------------------------------------------------------------
// Control register field positions and the event bit of the other registers
// ----------------------------------------------------------------------
`define TPT_BIT_RUN       1
`define TPT_BIT_IE        2
`define TPT_BIT_ACK       3
`define TPT_RATE_LO       4
`define TPT_RATE_HI       6
`define TPT_BIT_FLAG      7
`define TPT_BIT_EVENT     0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define TPT_RST_RATE      3'h0
`define TPT_RST_DATA      8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define TPT_CLK_HZ        20000000
`define TPT_OSC_HZ        32768
`define TPT_OSC_CYC       (`TPT_CLK_HZ / `TPT_OSC_HZ)
`define TPT_DIV_STAGES    15

`endif

// [tpt_pkg.sv]
package tpt_pkg;

  // Three-bit rate select code.
  typedef logic [2:0]  tpt_rate_t;

  // Register data byte.
  typedef logic [7:0]  tpt_byte_t;

  // Register port address.
  typedef logic [3:0]  tpt_addr_t;

endpackage : tpt_pkg

// [tpt_osc_sync.sv]
`timescale 1ns/1ns

module tpt_osc_sync (
  input  wire logic ref_clk,           // Bus clock.
  input  wire logic reset_n,           // Asynchronous reset, active low.
  input  wire logic crystal_osc_clock, // Slow oscillator clock as a level.
  output logic      osc_tick           // One pulse per oscillator rise.
);

  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic tick_r;
  logic tick_nxt;

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  // Only the settled second stage and its delayed copy are compared, so
  // a metastable first stage can never produce a false tick.
  always_comb begin
    tick_nxt = sync_r & ~prev_r;
  end

  // Two-stage synchroniser, delay stage and tick register.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      meta_r <= crystal_osc_clock;
      sync_r <= meta_r;
      prev_r <= sync_r;
      tick_r <= tick_nxt;
    end
  end

  assign osc_tick = tick_r;

endmodule : tpt_osc_sync

// [tpt_divider.sv]
`timescale 1ns/1ns
`include "tpt_regs.svh"

module tpt_divider #(
  parameter int STAGES = `TPT_DIV_STAGES  // Length of the divider chain.
) (
  input  wire logic              ref_clk,  // Bus clock.
  input  wire logic              reset_n,  // Asynchronous reset, active low.
  input  wire logic              osc_tick, // Advance enable, one cycle.
  input  wire logic              run,      // Counter run enable level.
  input  wire tpt_pkg::tpt_rate_t rate,    // Rate select code.
  output logic                   event_p,  // Rollover pulse, one cycle.
  output logic [STAGES-1:0]      count     // Chain value, for observation.
);

  logic [STAGES-1:0] cnt_r;
  logic [STAGES-1:0] cnt_nxt;
  logic              ev_r;
  logic              ev_nxt;
  logic [3:0]        tap;

  // Chain bit whose rise marks one divider period for a rate code.
  // R9 R10 tap per code
  function automatic logic [3:0] tap_index(input tpt_pkg::tpt_rate_t r);
    case (r)
      3'h0:    tap_index = 4'hE; // Divide by 32768.
      3'h1:    tap_index = 4'hC; // Divide by 8192.
      3'h2:    tap_index = 4'hA; // Divide by 2048.
      3'h3:    tap_index = 4'h6; // Divide by 128.
      3'h4:    tap_index = 4'h5; // Divide by 64.
      3'h5:    tap_index = 4'h4; // Divide by 32.
      3'h6:    tap_index = 4'h3; // Divide by 16.
      default: tap_index = 4'h2; // Divide by 8.
    endcase
  endfunction : tap_index

  // Next count and rollover detection.  The tap bit rises first after half
  // a period from zero and then once every full period.
  always_comb begin
    tap     = tap_index(rate);
    cnt_nxt = cnt_r;
    ev_nxt  = 1'b0;
    // R2 held at zero
    if (!run) begin
      cnt_nxt = '0;
    end else if (osc_tick) begin
      // R3 advance while enabled
      cnt_nxt = cnt_r + {{(STAGES-1){1'b0}}, 1'b1};
      // R8 half period first
      ev_nxt  = ~cnt_r[tap] & cnt_nxt[tap];
    end
  end

  // Chain and pulse registers.
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
      ev_r  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      ev_r  <= ev_nxt;
    end
  end

  assign event_p = ev_r;
  assign count   = cnt_r;

endmodule : tpt_divider

// [tpt_periodic_tick_tb.sv]
`timescale 1ns/1ns
`include "tpt_regs.svh"

module tpt_periodic_tick_tb;

  // ----------------------------------------------------------------------
  // Signals and scoreboard
  // ----------------------------------------------------------------------
  localparam int DIV [8] = '{32768, 8192, 2048, 128, 64, 32, 16, 8};

  logic               ref_clk = 1'b0;
  logic               reset_n = 1'b0;
  logic               crystal_osc_clock = 1'b0;
  logic               wait_mode = 1'b0;
  logic               stop_mode = 1'b0;
  logic               osc_run_in_stop = 1'b0;
  logic               wr_en = 1'b0;
  logic               rd_en = 1'b0;
  logic               rd_seen = 1'b0;
  logic               irq;
  logic               wakeup;
  tpt_pkg::tpt_addr_t addr = 4'h0;
  tpt_pkg::tpt_byte_t wr_data = 8'h00;
  tpt_pkg::tpt_byte_t rd_data;
  tpt_pkg::tpt_byte_t exp_q [$];
  int                 error_cnt = 0;
  int                 tests_run = 0;
  int                 rises = 0;
  int                 wake_cnt = 0;

  tpt_periodic_tick dut (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .crystal_osc_clock(crystal_osc_clock), .wait_mode(wait_mode),
    .stop_mode(stop_mode), .osc_run_in_stop(osc_run_in_stop),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .irq(irq), .wakeup(wakeup)
  );

  // Bus clock, 50 ns period.
  always #25 ref_clk = ~ref_clk;

  // Oscillator at 8 bus cycles a period, so the long dividers stay short.
  always begin
    repeat (4) @(posedge ref_clk);
    crystal_osc_clock <= ~crystal_osc_clock;
  end

  // Oscillator rises are counted for the period checks, wakeup pulses for the stop checks.
  always @(posedge crystal_osc_clock) rises++;
  always @(posedge ref_clk) if (wakeup === 1'b1) wake_cnt++;

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  // Read data stands only in the cycle after the strobe, so look there.
  always @(posedge ref_clk) rd_seen <= rd_en;
  always @(negedge ref_clk) begin
    if (rd_seen === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({24'h0, rd_data}, {24'h0, exp_q.pop_front()});
    end
  end

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  task automatic wr(input tpt_pkg::tpt_addr_t a, input tpt_pkg::tpt_byte_t d);
    @(posedge ref_clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge ref_clk);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input tpt_pkg::tpt_addr_t a, input tpt_pkg::tpt_byte_t e);
    @(posedge ref_clk);
    addr  <= a;
    rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd_en <= 1'b0;
  endtask : rd

  // Bounded wait for the interrupt level, polled off the clock edge.
  task automatic wait_irq(input int maxc);
    for (int i = 0; i < maxc && irq !== 1'b1; i++) @(negedge ref_clk);
  endtask : wait_irq

  function automatic tpt_pkg::tpt_byte_t ctl(input int r, input logic ie);
    return {1'b0, 3'(r), 1'b0, ie, 1'b1, 1'b0};
  endfunction : ctl

  // One rate code: stop, restart from zero, time the first two flags for divides up to 2048.
  task automatic run_code(input int c);
    int n;
    int base;
    n = DIV[c];
    wr(`TPT_OFS_CTRL, 8'h00);
    @(negedge crystal_osc_clock);
    base = rises;
    wr(`TPT_OFS_CTRL, ctl(c, 1'b1));
    if (n > 4096) begin
      // Too long to run out; no flag may come at the faster taps' times.
      repeat (1100) @(posedge crystal_osc_clock);
      repeat (8) @(negedge ref_clk);
      check({31'h0, irq}, 32'h0);
    end else begin
      wait_irq(n * 8 + 100);
      check(rises - base, n / 2);
      wr(`TPT_OFS_CLEAR, 8'h01);
      repeat (3) @(negedge ref_clk);
      check({31'h0, irq}, 32'h0);
      wait_irq(n * 8 + 100);
      check(rises - base, n + n / 2);
      wr(`TPT_OFS_CLEAR, 8'h01);
    end
  endtask : run_code

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    tpt_pkg::tpt_addr_t ua;
    void'($urandom(32'hF85F));
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd(`TPT_OFS_CTRL, 8'h00);
    rd(`TPT_OFS_STATUS, 8'h00);
    rd(`TPT_OFS_IRQ_EN, 8'h00);
    @(negedge ref_clk);
    check({30'h0, irq, wakeup}, 32'h0);
    for (int c = 0; c < 8; c++) run_code(c);
    wait_mode <= 1'b1;
    wr(`TPT_OFS_CTRL, 8'($urandom));
    rd(`TPT_OFS_CTRL, 8'h00);
    wait_irq(200);
    check({31'h0, irq}, 32'h1);
    @(posedge ref_clk);
    wait_mode <= 1'b0;
    rd(`TPT_OFS_CTRL, 8'hF6);
    wr(`TPT_OFS_IRQ_EN, 8'h00);
    wr(`TPT_OFS_CLEAR, 8'h00);
    rd(`TPT_OFS_STATUS, 8'h01);
    check({31'h0, irq}, 32'h0);
    rd(`TPT_OFS_CTRL, 8'hF2);
    wr(`TPT_OFS_IRQ_EN, 8'h01);
    repeat (3) @(negedge ref_clk);
    check({31'h0, irq}, 32'h1);
    wr(`TPT_OFS_CTRL, 8'h7E);
    rd(`TPT_OFS_CTRL, 8'h76);
    ua = 4'h1 + 4'($urandom_range(0, 2));
    wr(ua, 8'($urandom));
    rd(ua, 8'h00);
    rd(`TPT_OFS_STATUS, 8'h00);
    rd(`TPT_OFS_CLEAR, 8'h00);
    wait_irq(200);
    wr(`TPT_OFS_CLEAR, 8'h01);
    stop_mode <= 1'b1;
    rd(`TPT_OFS_CTRL, 8'h00);
    repeat (200) @(negedge ref_clk);
    check({31'h0, irq}, 32'h0);
    check(wake_cnt, 0);
    @(posedge ref_clk);
    osc_run_in_stop <= 1'b1;
    repeat (100) @(negedge ref_clk);
    check({31'h0, wake_cnt > 0}, 32'h1);
    check({31'h0, irq}, 32'h1);
    @(posedge ref_clk);
    stop_mode <= 1'b0;
    repeat (4) @(posedge ref_clk);
    wr(`TPT_OFS_CTRL, 8'h74);
    wr(`TPT_OFS_CLEAR, 8'h01);
    wait_mode <= 1'b1;
    repeat (100) @(negedge ref_clk);
    check({31'h0, irq}, 32'h0);
    @(posedge ref_clk);
    wait_mode <= 1'b0;
    print_verdict();
  end

  // Expected run is about 50,000 cycles; cut a hang well past that.
  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    print_verdict();
  end

endmodule : tpt_periodic_tick_tb
